// ### verilog/rpc_consts.svh
// Behaviour
// - Key-update replaces addressed volatile key with hash of received key data; once per power-up (not enforced: key_init is not checked).
// - Key-update holds busy across two separate keyed-hash computations.
// - Key-update needs address in range, counter initialised and matching signature.
// - Increment adds exactly one to addressed counter when all checks pass.
// - Increment checks 40-byte payload, address, counter and key init, signature, counter data.
// - Counter increment must not be corrupted or made ambiguous by a power glitch.
// - Counter request checks 48-byte payload, address, counter and key init, signature.
// - Counter request hashes tag plus 32-bit counter using addressed 256-bit key.
// - Failed check skips execution and posts error; all passing executes and posts success.
// - Command types 04h to FFh are reserved and set status bit 2.
// - Status read after types 00-02 repeats status byte until chip select rises.
// - Status read after good request returns status, tag, counter, signature: 49 bytes.
// - While busy, status read repeats status byte and omits tag, counter, signature.
// - Status reads zero after power-up and 80h after error-free first-phase command.
// - Bit 0 set while first-phase command executes, cleared on completion.
// - Bit 2: signature mismatch or range error, reserved type, or wrong payload size (a type 00 range error sets bit 1 instead).
// - Bit 3: types 02 and 03 with uninitialised key or counter.
// - Bit 4: type 02 received counter data differs from stored value.
// - Bit 5: fatal error such as program fail or no valid counter.
// - Status kept until first 8 command bits; busy or error set within 8 clocks.
// - Type 00 payload size is 64 bytes.
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// ****************************************
// Opcodes and command types
// ****************************************
`define RPC_OPC_CMD 8'h9B
`define RPC_OPC_STATUS 8'h96
`define RPC_TYPE_ROOT 8'h00
`define RPC_TYPE_KEY 8'h01
`define RPC_TYPE_INC 8'h02
`define RPC_TYPE_REQ 8'h03
`define RPC_TYPE_LAST 8'h03

// ****************************************
// Payload sizes and layout, in bytes
// ****************************************
`define RPC_LEN_ROOT 7'h40
`define RPC_LEN_KEY 7'h28
`define RPC_LEN_INC 7'h28
`define RPC_LEN_REQ 7'h30
`define RPC_SIG_LEN 7'h20
`define RPC_BUF_LEN 7'h30
`define RPC_RESP_LAST 7'h31
`define RPC_CNT_NUM 4

// ****************************************
// Status byte values and bits
// ****************************************
`define RPC_STS_RESET 8'h00
`define RPC_STS_DONE 8'h80
`define RPC_STS_BUSY 8'h01
`define RPC_STS_E1 8'h02
`define RPC_STS_E2 8'h04
`define RPC_STS_E3 8'h08
`define RPC_STS_E4 8'h10
`define RPC_STS_FATAL_BIT 5

`endif

// ### verilog/rpc_pkg.sv
`include "rpc_consts.svh"

package rpc_pkg;

    typedef enum logic [1:0] {
        RPC_IDLE,
        RPC_HASH1,
        RPC_HASH2
    } rpc_state_t;

    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic mosi_s1;
        logic mosi_s2;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [6:0] nbytes;
        logic [7:0] op;
        logic [7:0] tx;
        logic miso;
        logic oe_n;
        logic [47:0][7:0] pl;
        logic [7:0] status;
        logic resp_ok;
        rpc_state_t st;
        logic [7:0] ctype;
        logic [1:0] addr;
        logic [`RPC_CNT_NUM-1:0][255:0] hkey;
        logic [`RPC_CNT_NUM-1:0] key_init;
        logic [`RPC_CNT_NUM-1:0][31:0] cnt;
        logic [47:0][7:0] resp;
        logic hash_req;
        logic [255:0] hash_key;
        logic [383:0] hash_msg;
        logic [5:0] hash_len;
    } rpc_regs_t;

endpackage : rpc_pkg

// ### verilog/rpc_cmd_check.sv
`timescale 1ns/1ps
`include "rpc_consts.svh"

module rpc_cmd_check
    import rpc_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Serial flash pins
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe_n,
    // Nonvolatile state from the array side
    input wire logic [`RPC_CNT_NUM-1:0] i_counter_init,
    input wire logic [`RPC_CNT_NUM-1:0] i_root_key_init,
    input wire logic [255:0] i_root_key,
    output logic [1:0] o_root_key_addr,
    input wire logic i_fatal_error,
    // Hash engine
    output logic o_hash_req,
    output logic [255:0] o_hash_key,
    output logic [383:0] o_hash_msg,
    output logic [5:0] o_hash_len,
    input wire logic i_hash_done,
    input wire logic [255:0] i_hash_digest,
    // Status view
    output logic [7:0] o_counter_status_byte,
    output logic o_busy
);

    rpc_regs_t r;
    rpc_regs_t next_r;

    logic sck_rise;
    logic sck_fall;
    logic cs_end;
    logic reading;

    assign sck_rise = r.sck_s2 & ~r.sck_d;
    assign sck_fall = ~r.sck_s2 & r.sck_d;
    assign cs_end = r.cs_s2 & ~r.cs_d;
    assign reading = (r.op == `RPC_OPC_STATUS);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [7:0] byte_in;
        logic [7:0] err;
        logic [7:0] typ;
        logic [1:0] a;
        logic a_bad;
        logic [6:0] k1;
        logic sig_ok;
        logic cnt_ok;
        byte_in = 8'h00;
        err = 8'h00;
        typ = r.pl[1];
        a = r.pl[2][1:0];
        a_bad = (r.pl[2] >= 8'(`RPC_CNT_NUM));
        k1 = 7'(r.nbytes + 7'h01);
        sig_ok = 1'b1;
        cnt_ok = ({r.pl[4], r.pl[5], r.pl[6], r.pl[7]} == r.cnt[r.addr]);
        next_r = r;

        // Pin synchronisers
        next_r.sck_s1 = i_spi_sck;
        next_r.sck_s2 = r.sck_s1;
        next_r.sck_d = r.sck_s2;
        next_r.cs_s1 = i_spi_cs_n;
        next_r.cs_s2 = r.cs_s1;
        next_r.cs_d = r.cs_s2;
        next_r.mosi_s1 = i_spi_mosi;
        next_r.mosi_s2 = r.mosi_s1;

        // ****************************************
        // Serial frame
        // ****************************************
        if (r.cs_s2) begin
            next_r.bitcnt = 3'h0;
            next_r.nbytes = 7'h00;
            next_r.op = 8'h00;
            next_r.oe_n = 1'b1;
        end else if (sck_rise) begin
            byte_in = {r.sh[6:0], r.mosi_s2};
            next_r.sh = byte_in;
            next_r.bitcnt = 3'(r.bitcnt + 3'h1);
            if (r.bitcnt == 3'h7) begin
                if (r.nbytes < `RPC_BUF_LEN && r.st == RPC_IDLE &&
                        (r.nbytes == 7'h00 ? byte_in == `RPC_OPC_CMD :
                        r.op == `RPC_OPC_CMD)) begin
                    // Reads and dropped commands must not disturb a payload under check
                    next_r.pl[r.nbytes[5:0]] = byte_in;
                end
                if (r.nbytes != 7'h7F) begin
                    next_r.nbytes = k1;
                end
                if (r.nbytes == 7'h00) begin
                    next_r.op = byte_in;
                    // Busy posted as soon as the opcode byte is in
                    if (byte_in == `RPC_OPC_CMD && r.st == RPC_IDLE) begin
                        next_r.status = `RPC_STS_BUSY;
                        next_r.resp_ok = 1'b0;
                    end
                end
                if (r.nbytes == 7'h00 ? byte_in == `RPC_OPC_STATUS : reading) begin
                    // Payload only while idle and after a good request
                    if (r.resp_ok && !r.status[0] && k1 >= 7'h02 &&
                            k1 <= `RPC_RESP_LAST) begin
                        next_r.tx = r.resp[6'(k1 - 7'h02)];
                    end else begin
                        next_r.tx = r.status;
                    end
                end
            end
        end else if (sck_fall && reading && r.nbytes != 7'h00) begin
            next_r.miso = r.tx[7];
            next_r.tx = {r.tx[6:0], 1'b0};
            next_r.oe_n = 1'b0;
        end

        // ****************************************
        // Command checks at end of frame
        // ****************************************
        // A command whose frame ends while hashing is dropped; its busy was never posted
        if (cs_end && r.op == `RPC_OPC_CMD && r.st == RPC_IDLE) begin
            next_r.ctype = typ;
            next_r.addr = a;
            if (typ > `RPC_TYPE_LAST) begin
                err = `RPC_STS_E2;
            end else if (typ == `RPC_TYPE_ROOT) begin
                if (r.nbytes != `RPC_LEN_ROOT) begin
                    err = `RPC_STS_E2;
                end else if (a_bad || i_root_key_init[a]) begin
                    err = `RPC_STS_E1;
                end
            end else if (typ == `RPC_TYPE_KEY) begin
                if (r.nbytes != `RPC_LEN_KEY) begin
                    err = `RPC_STS_E2;
                end else if (a_bad) begin
                    err = `RPC_STS_E2;
                end else if (!i_counter_init[a]) begin
                    err = `RPC_STS_E1;
                end
            end else begin
                if (r.nbytes != (typ == `RPC_TYPE_INC ? `RPC_LEN_INC : `RPC_LEN_REQ)) begin
                    err = `RPC_STS_E2;
                end else if (a_bad) begin
                    err = `RPC_STS_E2;
                end else if (!i_counter_init[a] || !r.key_init[a]) begin
                    err = `RPC_STS_E3;
                end
            end
            if (err != 8'h00) begin
                next_r.status = err;
            end else if (typ == `RPC_TYPE_ROOT) begin
                // Root key storage is handled by the array side
                next_r.status = `RPC_STS_DONE;
            end else begin
                next_r.st = RPC_HASH1;
                next_r.hash_req = 1'b1;
                next_r.hash_key = (typ == `RPC_TYPE_KEY) ? i_root_key : r.hkey[a];
                next_r.hash_msg = r.pl;
                next_r.hash_len = 6'(r.nbytes - `RPC_SIG_LEN);
            end
        end

        // ****************************************
        // Hash sequencing
        // ****************************************
        case (r.st)
            RPC_IDLE: begin
                // Frame checks above decide whether hashing starts
            end
            RPC_HASH1: begin
                if (i_hash_done) begin
                    next_r.hash_req = 1'b0;
                    for (int j = 0; j < 32; j++) begin
                        if (r.pl[6'(r.hash_len + 6'(j))] != i_hash_digest[255 - 8 * j -: 8]) begin
                            sig_ok = 1'b0;
                        end
                    end
                    if (!sig_ok) begin
                        err = err | `RPC_STS_E2;
                    end
                    if (r.ctype == `RPC_TYPE_INC && !cnt_ok) begin
                        err = err | `RPC_STS_E4;
                    end
                    if (err != 8'h00) begin
                        next_r.status = err;
                        next_r.st = RPC_IDLE;
                    end else if (r.ctype == `RPC_TYPE_INC) begin
                        // Single-cycle commit: the counter never holds a partial value
                        next_r.cnt[r.addr] = 32'(r.cnt[r.addr] + 32'h1);
                        next_r.status = `RPC_STS_DONE;
                        next_r.st = RPC_IDLE;
                    end else if (r.ctype == `RPC_TYPE_KEY) begin
                        // Second hash keeps busy set
                        next_r.st = RPC_HASH2;
                        next_r.hash_req = 1'b1;
                        next_r.hash_key = i_root_key;
                        next_r.hash_msg = '0;
                        next_r.hash_msg[31:0] = r.pl[7:4];
                        next_r.hash_len = 6'h04;
                    end else begin
                        next_r.st = RPC_HASH2;
                        next_r.hash_req = 1'b1;
                        next_r.hash_key = r.hkey[r.addr];
                        next_r.hash_msg = '0;
                        next_r.hash_msg[95:0] = r.pl[15:4];
                        next_r.hash_msg[127:96] = {r.cnt[r.addr][7:0], r.cnt[r.addr][15:8],
                            r.cnt[r.addr][23:16], r.cnt[r.addr][31:24]};
                        next_r.hash_len = 6'h10;
                    end
                end
            end
            RPC_HASH2: begin
                if (i_hash_done) begin
                    next_r.hash_req = 1'b0;
                    next_r.st = RPC_IDLE;
                    next_r.status = `RPC_STS_DONE;
                    if (r.ctype == `RPC_TYPE_KEY) begin
                        next_r.hkey[r.addr] = i_hash_digest;
                        next_r.key_init[r.addr] = 1'b1;
                    end else begin
                        next_r.resp[15:0] = r.hash_msg[127:0];
                        for (int j = 0; j < 32; j++) begin
                            next_r.resp[16 + j] = i_hash_digest[255 - 8 * j -: 8];
                        end
                        next_r.resp_ok = 1'b1;
                    end
                end
            end
            default: begin
                next_r.st = RPC_IDLE;
            end
        endcase

        // Fatal condition sets bit 5 on top of whatever was posted this cycle
        if (i_fatal_error) begin
            next_r.status[`RPC_STS_FATAL_BIT] = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            r <= '0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_d <= 1'b1;
            r.oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_spi_miso = r.miso;
    assign o_spi_miso_oe_n = r.oe_n;
    assign o_root_key_addr = r.pl[2][1:0];
    assign o_hash_req = r.hash_req;
    assign o_hash_key = r.hash_key;
    assign o_hash_msg = r.hash_msg;
    assign o_hash_len = r.hash_len;
    assign o_counter_status_byte = r.status;
    assign o_busy = r.status[0];

endmodule : rpc_cmd_check

// ### verif/rpc_cmd_check_sva.sv
`timescale 1ns/1ps
module rpc_cmd_check_sva (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic i_spi_cs_n,
    input wire logic i_fatal_error,
    input wire logic i_hash_done,
    input wire logic o_spi_miso_oe_n,
    input wire logic o_hash_req,
    input wire logic [255:0] o_hash_key,
    input wire logic [383:0] o_hash_msg,
    input wire logic [7:0] o_counter_status_byte,
    input wire logic o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ****
    // Checks
    // ****
    property p_oe; $rose(i_spi_cs_n) |-> ##[1:6] o_spi_miso_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("output enable left on");
    property p_busy;
        o_busy == o_counter_status_byte[0] && !(o_busy && o_counter_status_byte[7]);
    endproperty
    a_busy: assert property (p_busy) else $error("busy differs from bit 0");
    property p_fatal; i_fatal_error |-> ##[1:2] o_counter_status_byte[5]; endproperty
    a_fatal: assert property (p_fatal) else $error("fatal bit not set");
    property p_rst; $fell(i_rst) |-> o_counter_status_byte == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("status not zero after reset");
    // Engine may latch key and message at any cycle of the request
    property p_hold;
        o_hash_req && !i_hash_done |=> o_hash_req && $stable(o_hash_key) && $stable(o_hash_msg);
    endproperty
    a_hold: assert property (p_hold) else $error("hash request unstable");
    property p_keep;
        $fell(i_spi_cs_n) && !i_fatal_error && !o_busy |=> $stable(o_counter_status_byte)[*8];
    endproperty
    a_keep: assert property (p_keep) else $error("status changed early");
    property p_set; $rose(o_busy) |-> !i_spi_cs_n; endproperty
    a_set: assert property (p_set) else $error("busy outside a frame");
    property p_end;
        $fell(o_busy) |-> o_counter_status_byte == 8'h80 || o_counter_status_byte[5:1] != 5'h00;
    endproperty
    a_end: assert property (p_end) else $error("no result posted");
endmodule : rpc_cmd_check_sva

bind rpc_cmd_check rpc_cmd_check_sva rpc_cmd_check_sva_inst (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n),
    .i_fatal_error(i_fatal_error), .i_hash_done(i_hash_done),
    .o_spi_miso_oe_n(o_spi_miso_oe_n), .o_hash_req(o_hash_req), .o_hash_key(o_hash_key),
    .o_hash_msg(o_hash_msg), .o_counter_status_byte(o_counter_status_byte), .o_busy(o_busy));

// ### verif/rpc_host_model.sv
`timescale 1ns/1ps
module rpc_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Serial link
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    logic [7:0] rb [64];
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // ****
    // Link cycles, half period of four system clocks
    // ****
    task tick;
        repeat (4) @(posedge i_sys_clk);
    endtask : tick
    task xb(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            o_mosi <= b[i];
            tick;
            o_sck <= 1'b1;
            r[i] = i_miso;
            tick;
            o_sck <= 1'b0;
        end
    endtask : xb
    // Signature always 32 bytes of A5h, to match the bench's engine
    task op1(input logic [7:0] t, input logic [7:0] a, input int n, input logic [31:0] d);
        logic [7:0] b;
        logic [7:0] r;
        o_cs_n <= 1'b0;
        tick;
        for (int i = 0; i < n; i++) begin
            b = i == 0 ? 8'h9B : i == 1 ? t : i == 2 ? a : i == 3 ? 8'h00 :
                i >= n - 32 ? 8'hA5 : i < 8 ? d[(7 - i) * 8 +: 8] : 8'(8'h10 + i);
            xb(b, r);
        end
        tick;
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi;
        tick;
    endtask : op1
    // Reads may stop early; bytes past 49 are ignored by callers
    task rd(input int n);
        logic [7:0] r;
        o_cs_n <= 1'b0;
        tick;
        xb(8'h96, r);
        for (int i = 0; i < n; i++) begin
            xb(8'h00, rb[i]);
        end
        tick;
        o_cs_n <= 1'b1;
        tick;
    endtask : rd
endmodule : rpc_host_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_fatal_error = 1'b0;
    logic i_hash_done = 1'b0;
    logic sck, cs_n, mosi, miso, oe_n, busy, hreq;
    logic [7:0] sts;
    logic [3:0] cinit = 4'h1;
    logic [3:0] rki = 4'h0;
    logic [255:0] dig = {32{8'hA5}};
    wire host_miso;
    // Released line shows the opposite level, so a late enable is caught
    assign host_miso = oe_n ? ~miso : miso;
    int fails = 0, total_checks = 0, cyc = 0, hc = 0, hlat = 3, nh = 0, n0;
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    rpc_host_model rpc_host_model_inst (.i_sys_clk(i_sys_clk), .o_sck(sck), .o_cs_n(cs_n),
        .o_mosi(mosi), .i_miso(host_miso));
    rpc_cmd_check rpc_cmd_check_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_sck(sck),
        .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n),
        .i_counter_init(cinit), .i_root_key_init(rki), .i_root_key({8{32'h0F1E2D3C}}),
        .o_root_key_addr(), .i_fatal_error(i_fatal_error), .o_hash_req(hreq), .o_hash_key(),
        .o_hash_msg(), .o_hash_len(), .i_hash_done(i_hash_done),
        .i_hash_digest(dig), .o_counter_status_byte(sts), .o_busy(busy));
    // ****
    // Hash engine, latency set per scenario
    // ****
    always @(posedge i_sys_clk) begin
        i_hash_done <= 1'b0;
        if (hreq && !i_hash_done) begin
            hc <= hc + 1;
            if (hc >= hlat) begin
                i_hash_done <= 1'b1;
                hc <= 0;
                nh <= nh + 1;
            end
        end else begin
            hc <= 0;
        end
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt;
        int k = 0;
        repeat (12) @(posedge i_sys_clk);
        while (busy !== 1'b0 && k < 4000) begin
            @(posedge i_sys_clk);
            k++;
        end
    endtask : wt
    // Status must repeat across the whole read
    task automatic cmd(input logic [7:0] t, a, input int n, input logic [31:0] d, logic [7:0] e);
        rpc_host_model_inst.op1(t, a, n, d);
        wt;
        rpc_host_model_inst.rd(2);
        chk(rpc_host_model_inst.rb[0], e);
        chk(rpc_host_model_inst.rb[1], e);
    endtask : cmd
    task automatic t_request;
        hlat = 400;
        rpc_host_model_inst.op1(8'h03, 8'h00, 48, 32'h14151617);
        rpc_host_model_inst.rd(3);
        for (int j = 0; j < 3; j++) chk(rpc_host_model_inst.rb[j], 8'h01);
        hlat = 3;
        wt;
        rpc_host_model_inst.rd(50);
        chk(rpc_host_model_inst.rb[0], 8'h80);
        // Payload judged whatever the status byte in rb[0] shows, error or not
        for (int j = 1; j < 49; j++) chk(rpc_host_model_inst.rb[j], j < 13 ? 8'(8'h13 + j) :
            j == 16 ? 8'h02 : j < 17 ? 8'h00 : 8'hA5);
    endtask : t_request
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        rpc_host_model_inst.rd(1);
        chk(rpc_host_model_inst.rb[0], 8'h00);
        cmd(8'h04, 8'h00, 40, 0, 8'h04);
        cmd(8'hFF, 8'h00, 40, 0, 8'h04);
        cmd(8'h02, 8'h00, 39, 0, 8'h04);
        cmd(8'h00, 8'h05, 64, 0, 8'h02);
        cmd(8'h00, 8'h00, 64, 0, 8'h80);
        rki <= 4'h1;
        cmd(8'h00, 8'h00, 64, 0, 8'h02);
        cmd(8'h02, 8'h00, 40, 0, 8'h08);
        cmd(8'h01, 8'h01, 40, 0, 8'h02);
        cmd(8'h01, 8'h04, 40, 0, 8'h04);
        n0 = nh;
        cmd(8'h01, 8'h00, 40, 32'h1234, 8'h80);
        chk(8'(nh - n0), 8'h02);
        cmd(8'h02, 8'h00, 40, 0, 8'h80);
        cmd(8'h02, 8'h00, 40, 0, 8'h10);
        cmd(8'h02, 8'h00, 40, 1, 8'h80);
        t_request;
        dig <= '0;
        cmd(8'h02, 8'h00, 40, 2, 8'h04);
        dig <= {32{8'hA5}};
        cmd(8'h02, 8'h00, 40, 2, 8'h80);
        @(posedge i_sys_clk);
        i_fatal_error <= 1'b1;
        @(posedge i_sys_clk);
        i_fatal_error <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        chk({7'h00, sts[5]}, 8'h01);
        conclude;
    end
endmodule : tb
